// ==== core/analog_if_map.vh ====
// Constants for the analog subsystem interface block
`ifndef ANALOG_IF_MAP_VH
`define ANALOG_IF_MAP_VH
`define N_TRIG 8
`define N_SRC 22
`define SEL_W 5
`define N_EOC 8
`define N_DMA_EOC 4
`define N_CMP 6
`define N_CMP_PIN 8
`define CMP_PIN_SEL_W 3
`define RES_W 12
`define ADDR_W 10
`define DATA_W 16
`define CH_W 4
// Analog address map: result window below RESULT_TOP, other registers above
`define RESULT_BASE 10'h000
`define RESULT_TOP 10'h040
// Requester indices, fixed priority lowest index first
`define REQ_CTL_CPU 2'h0
`define REQ_CTL_DMA 2'h1
`define REQ_MST_CPU 2'h2
`define REQ_MST_DMA 2'h3
`define N_REQ 4
// Status bit positions
`define ST_PWR 0
`define ST_CLK 1
`define ST_BUS 2
`define ST_TRIG 3
`define ST_INT 4
`define ST_ERR 5
`define ST_W 6
`endif

// ==== core/analog_subsystem_interface.v ====
// Interface between two digital subsystems and the analog converters
// Behaviour
// RULE1: Arbitrate converter and comparator register cycles between both subsystems.
// RULE2: Result registers readable by all; other registers only by control processor.
// RULE3: Control processor and control DMA are two separate request ports.
// RULE4: Route 22 start sources onto 8 shared start triggers.
// RULE5: Each interrupt is first converter event ANDed with second converter event.
// RULE6: All eight interrupts to both subsystems; four also to control DMA.
// RULE7: Converters store 12-bit results and select among 16 channels.
// RULE8: Two channels sampled together; further channels converted one after another.
// RULE9: Conversions start only on control-side start triggers.
// RULE10: End-of-conversion interrupt raised when results are ready.
// RULE11: Six comparator outputs mapped onto six of eight pins.
// RULE12: System routes comparator pins externally to trip inputs of pulse outputs.
// RULE13: Eight trigger selects each choose one of 22 sources.
// RULE14: Arbiter accepts up to four simultaneous cycles before forwarding.
// RULE15: Each subsystem reads a status of power, clock and propagation.
// RULE16: Fixed priority grant of one requester; others held until completion.
// RULE17: Master access to non-result registers has no effect and flags error.
`timescale 1ns/100ps
`include "analog_if_map.vh"
module analog_subsystem_interface #(
  parameter N_REQ = `N_REQ,
  parameter AW = `ADDR_W,
  parameter DW = `DATA_W
) (
  input wire i_mclk, // 200 MHz clock
  input wire i_rst_n, // Synchronous reset, active low
  input wire [N_REQ-1:0] i_req, // Request per port: ctl cpu, ctl dma, mst cpu, mst dma
  input wire [N_REQ-1:0] i_wr, // Write when high
  input wire [N_REQ*AW-1:0] i_addr, // Address per port
  input wire [N_REQ*DW-1:0] i_wdata, // Write data per port
  output reg [N_REQ-1:0] o_done, // One-cycle completion per port
  output reg [N_REQ-1:0] o_err, // One-cycle access refused per port
  output reg [DW-1:0] o_rdata, // Read data of completed cycle
  output reg o_a_req, // Analog-side cycle request
  output reg o_a_wr, // Analog-side write
  output reg [AW-1:0] o_a_addr, // Analog-side address
  output reg [DW-1:0] o_a_wdata, // Analog-side write data
  input wire i_a_ack, // Analog-side acknowledge, same clock
  input wire [DW-1:0] i_a_rdata, // Analog-side read data
  input wire [`N_SRC-1:0] i_soc_src, // Control-side start sources
  input wire [`N_TRIG*`SEL_W-1:0] i_trig_sel, // Trigger source selects
  output reg [`N_TRIG-1:0] o_soc, // Start triggers to both converters
  input wire [`N_EOC-1:0] i_eoc1, // First converter end-of-conversion events
  input wire [`N_EOC-1:0] i_eoc2, // Second converter end-of-conversion events
  output reg [`N_EOC-1:0] o_int_ctl, // Interrupts to control expander
  output reg [`N_EOC-1:0] o_int_mst, // Interrupts to master subsystem
  output reg [`N_DMA_EOC-1:0] o_int_dma, // Interrupts to control DMA
  input wire [`N_CMP-1:0] i_cmp, // Comparator outputs, asynchronous
  input wire [`N_CMP*`CMP_PIN_SEL_W-1:0] i_cmp_pin_sel, // Pin choice per comparator
  output reg [`N_CMP_PIN-1:0] o_cmp_pin, // Secondary pin multiplexer pins
  input wire i_pwr_ok, // Analog power good, asynchronous
  input wire i_aclk_ok, // Analog clock present, asynchronous
  input wire i_err_clr, // Clears error flag, one-cycle pulse
  output reg [`ST_W-1:0] o_ctl_status, // Control-side bus status
  output reg [`ST_W-1:0] o_mst_status, // Master-side bus status
  output reg o_if_err // Interface error flag, sticky
);
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;
  reg [1:0] state;
  reg [1:0] gnt;
  reg [N_REQ-1:0] pend;
  reg [N_REQ-1:0] pend_wr;
  reg [N_REQ*AW-1:0] pend_addr;
  reg [N_REQ*DW-1:0] pend_wdata;
  reg [1:0] next_gnt;
  reg next_found;
  reg [`N_CMP-1:0] cmp_s1;
  reg [`N_CMP-1:0] cmp_s2;
  reg [1:0] pwr_s;
  reg [1:0] clk_s;
  reg seen_bus;
  reg seen_trig;
  reg seen_int;
  wire [`N_TRIG-1:0] trig;
  wire [`N_EOC-1:0] eoc_and;
  integer i;
  integer p;
  integer k;

  // Result window test
  function is_result;
    input [AW-1:0] a;
    begin
      is_result = (a >= `RESULT_BASE) && (a < `RESULT_TOP);
    end
  endfunction

  // Only control processor may reach non-result registers
  function allowed;
    input [1:0] who;
    input [AW-1:0] a;
    input w;
    begin
      if (who == `REQ_CTL_CPU)
        allowed = 1'b1;
      else if (who == `REQ_CTL_DMA)
        allowed = is_result(a) && !w; // RULE2
      else
        allowed = is_result(a) && !w; // RULE2
    end
  endfunction

  // Start trigger routing
  trigger_router #(
    .N_TRIG(`N_TRIG),
    .N_SRC(`N_SRC),
    .SEL_W(`SEL_W)
  ) u_trig (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_src(i_soc_src),
    .i_sel(i_trig_sel),
    .o_trig(trig)
  );

  // Fixed priority pick among pending ports, lowest index wins
  always @* begin
    next_gnt = 2'h0;
    next_found = 1'b0;
    for (p = N_REQ - 1; p >= 0; p = p - 1) begin
      if (pend[p]) begin
        next_gnt = p[1:0]; // RULE16
        next_found = 1'b1;
      end
    end
  end

  // Capture, arbitrate and forward register cycles
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      gnt <= 2'h0;
      pend <= {N_REQ{1'b0}};
      pend_wr <= {N_REQ{1'b0}};
      pend_addr <= {N_REQ*AW{1'b0}};
      pend_wdata <= {N_REQ*DW{1'b0}};
      o_done <= {N_REQ{1'b0}};
      o_err <= {N_REQ{1'b0}};
      o_rdata <= {DW{1'b0}};
      o_a_req <= 1'b0;
      o_a_wr <= 1'b0;
      o_a_addr <= {AW{1'b0}};
      o_a_wdata <= {DW{1'b0}};
      o_if_err <= 1'b0;
      seen_bus <= 1'b0;
    end else begin
      o_done <= {N_REQ{1'b0}};
      o_err <= {N_REQ{1'b0}};
      // Every port owns a holding slot so four can arrive together
      for (i = 0; i < N_REQ; i = i + 1) begin
        if (i_req[i] && !pend[i]) begin
          pend[i] <= 1'b1; // RULE14 RULE3
          pend_wr[i] <= i_wr[i];
          pend_addr[i*AW +: AW] <= i_addr[i*AW +: AW];
          pend_wdata[i*DW +: DW] <= i_wdata[i*DW +: DW];
        end
      end
      case (state)
        ST_IDLE: begin
          if (next_found) begin
            gnt <= next_gnt;
            if (allowed(next_gnt, pend_addr[next_gnt*AW +: AW], pend_wr[next_gnt])) begin
              o_a_req <= 1'b1; // RULE1
              o_a_wr <= pend_wr[next_gnt];
              o_a_addr <= pend_addr[next_gnt*AW +: AW];
              o_a_wdata <= pend_wdata[next_gnt*DW +: DW];
              state <= ST_BUSY;
            end else begin
              pend[next_gnt] <= 1'b0; // RULE17
              o_err[next_gnt] <= 1'b1;
              o_done[next_gnt] <= 1'b1;
              o_if_err <= 1'b1;
            end
          end
        end
        ST_BUSY: begin
          // Others wait in their slots until this ack
          if (i_a_ack) begin
            o_a_req <= 1'b0; // RULE16
            // Result words carry only the converter value; upper bits are cleared
            if (is_result(o_a_addr))
              o_rdata <= {{(DW-`RES_W){1'b0}}, i_a_rdata[`RES_W-1:0]}; // RULE7
            else
              o_rdata <= i_a_rdata;
            o_done[gnt] <= 1'b1;
            pend[gnt] <= 1'b0;
            seen_bus <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          o_a_req <= 1'b0;
        end
      endcase
      if (i_err_clr && !(state == ST_IDLE && next_found &&
          !allowed(next_gnt, pend_addr[next_gnt*AW +: AW], pend_wr[next_gnt])))
        o_if_err <= 1'b0;
    end
  end

  assign eoc_and = i_eoc1 & i_eoc2; // RULE5

  // Triggers, interrupts, comparator pins and status
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_soc <= {`N_TRIG{1'b0}};
      o_int_ctl <= {`N_EOC{1'b0}};
      o_int_mst <= {`N_EOC{1'b0}};
      o_int_dma <= {`N_DMA_EOC{1'b0}};
      cmp_s1 <= {`N_CMP{1'b0}};
      cmp_s2 <= {`N_CMP{1'b0}};
      o_cmp_pin <= {`N_CMP_PIN{1'b0}};
      pwr_s <= 2'h0;
      clk_s <= 2'h0;
      seen_trig <= 1'b0;
      seen_int <= 1'b0;
      o_ctl_status <= {`ST_W{1'b0}};
      o_mst_status <= {`ST_W{1'b0}};
    end else begin
      o_soc <= trig; // RULE9 RULE4 RULE8
      o_int_ctl <= eoc_and; // RULE6 RULE10
      o_int_mst <= eoc_and; // RULE6 RULE10
      o_int_dma <= eoc_and[`N_DMA_EOC-1:0]; // RULE6
      cmp_s1 <= i_cmp;
      cmp_s2 <= cmp_s1;
      o_cmp_pin <= {`N_CMP_PIN{1'b0}};
      for (k = 0; k < `N_CMP; k = k + 1) begin
        if (cmp_s2[k])
          o_cmp_pin[i_cmp_pin_sel[k*`CMP_PIN_SEL_W +: `CMP_PIN_SEL_W]] <= 1'b1; // RULE11
      end
      pwr_s <= {pwr_s[0], i_pwr_ok};
      clk_s <= {clk_s[0], i_aclk_ok};
      if (|trig)
        seen_trig <= 1'b1;
      if (|eoc_and)
        seen_int <= 1'b1;
      o_ctl_status <= {o_if_err, seen_int, seen_trig, seen_bus, clk_s[1], pwr_s[1]}; // RULE15
      o_mst_status <= {o_if_err, seen_int, seen_trig, seen_bus, clk_s[1], pwr_s[1]}; // RULE15
    end
  end
endmodule // analog_subsystem_interface

// ==== core/trigger_router.v ====
// Routes conversion-start sources onto shared start triggers
`timescale 1ns/100ps
`include "analog_if_map.vh"
module trigger_router #(
  parameter N_TRIG = `N_TRIG,
  parameter N_SRC = `N_SRC,
  parameter SEL_W = `SEL_W
) (
  input wire i_mclk, // System clock
  input wire i_rst_n, // Synchronous reset, active low
  input wire [N_SRC-1:0] i_src, // Start sources, same clock domain
  input wire [N_TRIG*SEL_W-1:0] i_sel, // Per trigger source select
  output reg [N_TRIG-1:0] o_trig // Registered start triggers
);
  integer t;
  // Each trigger picks one of the sources; out of range selects nothing
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_trig <= {N_TRIG{1'b0}};
    end else begin
      for (t = 0; t < N_TRIG; t = t + 1) begin
        if (i_sel[t*SEL_W +: SEL_W] < N_SRC)
          o_trig[t] <= i_src[i_sel[t*SEL_W +: SEL_W]]; // RULE4 RULE13
        else
          o_trig[t] <= 1'b0;
      end
    end
  end
endmodule // trigger_router

// ==== testbench/analog_if_sva.sv ====
// Port assertions for the analog subsystem interface
`timescale 1ns/100ps
module analog_if_sva (
  input wire i_mclk, // Clock
  input wire i_rst_n, // Reset, active low
  input wire [7:0] i_eoc1, // First events
  input wire [7:0] i_eoc2, // Second events
  input wire [7:0] o_int_ctl, // Control ints
  input wire [7:0] o_int_mst, // Master ints
  input wire [3:0] o_int_dma, // DMA ints
  input wire [3:0] o_done, // Completions
  input wire [3:0] o_err, // Refusals
  input wire o_if_err, // Error flag
  input wire o_a_req, // Analog request
  input wire [9:0] o_a_addr, // Analog address
  input wire i_a_ack // Analog ack
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Interrupt fan-out and combining
  a_int_and: assert property ($past(i_rst_n) && $past(i_rst_n, 2) |->
    o_int_ctl == $past(i_eoc1 & i_eoc2)) else $error("interrupt not AND of events");
  a_int_mst: assert property (o_int_mst == o_int_ctl)
    else $error("master interrupts differ");
  a_int_dma: assert property (o_int_dma == o_int_ctl[3:0])
    else $error("dma interrupts differ");
  // Analog cycle handling
  a_cycle_hold: assert property (o_a_req && !i_a_ack |=> o_a_req && $stable(o_a_addr))
    else $error("analog cycle not held");
  a_ack_done: assert property (o_a_req && i_a_ack |=> (o_done & ~o_err) != 4'h0)
    else $error("ack without completion");
  a_done_ack: assert property ((o_done & ~o_err) != 4'h0 |-> $past(o_a_req && i_a_ack))
    else $error("completion without ack");
  a_err_done: assert property ((o_err & ~o_done) == 4'h0)
    else $error("refusal without completion");
  a_err_flag: assert property (o_err != 4'h0 |-> ##[0:1] o_if_err)
    else $error("refusal not flagged");
endmodule // analog_if_sva
bind analog_subsystem_interface analog_if_sva u_sva (
  .i_mclk(i_mclk),
  .i_rst_n(i_rst_n),
  .i_eoc1(i_eoc1),
  .i_eoc2(i_eoc2),
  .o_int_ctl(o_int_ctl),
  .o_int_mst(o_int_mst),
  .o_int_dma(o_int_dma),
  .o_done(o_done),
  .o_err(o_err),
  .o_if_err(o_if_err),
  .o_a_req(o_a_req),
  .o_a_addr(o_a_addr),
  .i_a_ack(i_a_ack)
);

// ==== testbench/analog_regs_model.sv ====
// Analog-side register model answering interface bus cycles
`timescale 1ns/100ps
module analog_regs_model (
  input wire i_mclk, // Clock
  input wire o_a_req, // Cycle request
  input wire o_a_wr, // Write
  input wire [9:0] o_a_addr, // Address
  input wire [15:0] o_a_wdata, // Write data
  input wire i_slow, // Answer late
  output reg i_a_ack = 1'b0, // Acknowledge
  output reg [15:0] i_a_rdata = 16'h0 // Read data
);
  reg [15:0] mem [0:63];
  reg [2:0] wait_cnt = 3'h0;
  // Answer after zero or four waits; data toggles when idle
  always @(posedge i_mclk) begin
    i_a_ack <= 1'b0;
    i_a_rdata <= ~i_a_rdata;
    if (o_a_req && !i_a_ack) begin
      if (wait_cnt != (i_slow ? 3'h4 : 3'h0)) begin
        wait_cnt <= wait_cnt + 3'h1;
      end else begin
        wait_cnt <= 3'h0;
        i_a_ack <= 1'b1;
        if (o_a_wr) mem[o_a_addr[5:0]] <= o_a_wdata;
        // Result reads carry junk above the 12-bit value
        i_a_rdata <= (o_a_addr < 10'h040) ? {6'h33, o_a_addr} : mem[o_a_addr[5:0]];
      end
    end
  end
endmodule // analog_regs_model

// ==== testbench/analog_subsystem_interface_tb.sv ====
// Self-checking bench for the analog subsystem interface
`timescale 1ns/100ps
module analog_subsystem_interface_tb;
  reg i_mclk = 1'b0;
  reg i_rst_n = 1'b0;
  reg [3:0] i_req = 4'h0, i_wr = 4'h0;
  reg [39:0] i_addr = 40'h0, i_trig_sel = 40'h0;
  reg [63:0] i_wdata = 64'h0;
  reg [21:0] i_soc_src = 22'h0;
  reg [7:0] i_eoc1 = 8'h0, i_eoc2 = 8'h0;
  reg [5:0] i_cmp = 6'h0;
  reg [17:0] i_cmp_pin_sel = 18'h0;
  reg i_pwr_ok = 1'b0, i_aclk_ok = 1'b0, i_err_clr = 1'b0, i_slow = 1'b0;
  wire [3:0] o_done, o_err, o_int_dma;
  wire [15:0] o_rdata, o_a_wdata, i_a_rdata;
  wire o_a_req, o_a_wr, i_a_ack, o_if_err;
  wire [9:0] o_a_addr;
  wire [7:0] o_soc, o_int_ctl, o_int_mst, o_cmp_pin;
  wire [5:0] o_ctl_status, o_mst_status;
  integer miscompares = 0, n_checks = 0, j, s;
  reg [15:0] ord;
  reg [7:0] e;
  always #2.5 i_mclk = ~i_mclk;
  analog_subsystem_interface i_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_done(o_done), .o_err(o_err),
    .o_rdata(o_rdata), .o_a_req(o_a_req), .o_a_wr(o_a_wr), .o_a_addr(o_a_addr),
    .o_a_wdata(o_a_wdata), .i_a_ack(i_a_ack), .i_a_rdata(i_a_rdata),
    .i_soc_src(i_soc_src), .i_trig_sel(i_trig_sel), .o_soc(o_soc),
    .i_eoc1(i_eoc1), .i_eoc2(i_eoc2), .o_int_ctl(o_int_ctl), .o_int_mst(o_int_mst),
    .o_int_dma(o_int_dma), .i_cmp(i_cmp), .i_cmp_pin_sel(i_cmp_pin_sel),
    .o_cmp_pin(o_cmp_pin), .i_pwr_ok(i_pwr_ok), .i_aclk_ok(i_aclk_ok),
    .i_err_clr(i_err_clr), .o_ctl_status(o_ctl_status), .o_mst_status(o_mst_status),
    .o_if_err(o_if_err)
  );
  analog_regs_model i_far (
    .i_mclk(i_mclk), .o_a_req(o_a_req), .o_a_wr(o_a_wr), .o_a_addr(o_a_addr),
    .o_a_wdata(o_a_wdata), .i_slow(i_slow), .i_a_ack(i_a_ack), .i_a_rdata(i_a_rdata)
  );
  task check(input [63:0] seen, input [63:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // Requests on mask; bad ports expect refusal; order of completions kept in ord
  task run(input [3:0] m, input [3:0] bad, input w, input [9:0] a, input [15:0] d,
           input [15:0] x, input sl);
    integer t, p, g;
    reg [3:0] slot, nreq;
    reg busy, hit;
    begin
      ord = 16'h0;
      slot = 4'h0;
      busy = 1'b0;
      g = 0;
      @(posedge i_mclk);
      i_req <= m;
      i_wr <= {4{w}};
      i_addr <= {4{a}};
      i_wdata <= {4{d}};
      i_slow <= sl;
      #1;
      for (t = 1; t < 80 && i_req != 4'h0; t = t + 1) begin
        @(posedge i_mclk);
        // Port answered at this edge drops its request at once, else it is taken again
        nreq = i_req;
        hit = 1'b0;
        if (busy && i_a_ack) begin
          hit = 1'b1;
          busy = 1'b0;
        end else if (!busy && slot != 4'h0) begin
          g = slot[0] ? 0 : slot[1] ? 1 : slot[2] ? 2 : 3;
          hit = bad[g];
          busy = !bad[g];
        end
        slot = slot | i_req;
        if (hit) begin
          slot[g] = 1'b0;
          nreq[g] = 1'b0;
        end
        i_req <= nreq;
        #1;
        for (p = 0; p < 4; p = p + 1) if (o_done[p]) ord = {ord[11:0], 4'(p)};
        check(o_err, o_done & bad);
        if ((o_done & ~bad) != 4'h0 && !w) check(o_rdata, x);
      end
      check(i_req, 4'h0);
    end
  endtask
  // Access rights, refusal, priority and error flag
  task t_bus;
    begin
      run(4'h1, 4'h0, 1'b1, 10'h100, 16'h1234, 16'h0, 1'b1);
      run(4'h4, 4'h4, 1'b1, 10'h100, 16'hbeef, 16'h0, 1'b0);
      @(posedge i_mclk);
      i_err_clr <= 1'b1;
      #1;
      check(o_if_err, 1'b1);
      @(posedge i_mclk);
      i_err_clr <= 1'b0;
      run(4'h8, 4'h0, 1'b0, 10'h03f, 16'h0, 16'h0c3f, 1'b0);
      check(o_if_err, 1'b0);
      run(4'hf, 4'h0, 1'b0, 10'h010, 16'h0, 16'h0c10, 1'b1);
      check(ord, 16'h0123);
      run(4'hf, 4'he, 1'b0, 10'h100, 16'h0, 16'h1234, 1'b0);
      check(ord, 16'h0123);
      check({o_mst_status[2:0], o_ctl_status[2:0]}, 6'h3f);
      $display("bus test done");
    end
  endtask
  // Each source to its selected trigger; select 22 routes nothing
  task t_trig;
    begin
      @(posedge i_mclk);
      for (j = 0; j < 8; j = j + 1) i_trig_sel[j*5 +: 5] <= 5'(j * 3);
      for (s = 0; s < 23; s = s + 1) begin
        @(posedge i_mclk);
        i_soc_src <= (s < 22) ? 22'h1 << s : 22'h3fffff;
        if (s == 22) i_trig_sel <= {8{5'h16}};
        repeat (3) @(posedge i_mclk);
        #1;
        for (j = 0; j < 8; j = j + 1) e[j] = (s == j * 3);
        check(o_soc, e);
      end
      $display("trigger test done");
    end
  endtask
  // Combined interrupts and comparator pins
  task t_evt;
    begin
      @(posedge i_mclk);
      for (j = 0; j < 6; j = j + 1) i_cmp_pin_sel[j*3 +: 3] <= 3'(j + 2);
      for (s = 0; s < 16; s = s + 1) begin
        @(posedge i_mclk);
        i_eoc1 <= 8'(s * 37);
        i_eoc2 <= 8'(s * 91);
        i_cmp <= 6'(s * 11);
        repeat (4) @(posedge i_mclk);
        #1;
        e = 8'(s * 37) & 8'(s * 91);
        check(o_int_ctl, e);
        check({o_int_mst, o_int_dma}, {e, e[3:0]});
        check(o_cmp_pin, {6'(s * 11), 2'h0});
      end
      check({o_mst_status, o_ctl_status}, 12'hfff);
      $display("event test done");
    end
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    i_pwr_ok <= 1'b1;
    i_aclk_ok <= 1'b1;
    repeat (3) @(posedge i_mclk);
    t_bus;
    t_trig;
    t_evt;
    final_report;
  end
  // Watchdog
  initial begin
    #100000;
    miscompares = miscompares + 1;
    final_report;
  end
endmodule // analog_subsystem_interface_tb
